/* include/pib_consts.svh */
/*
 * Register offsets, field masks, bit positions and reset values of the
 * peripheral interrupt enable bank.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef PIB_CONSTS_SVH
`define PIB_CONSTS_SVH

// byte addresses on the register bus
`define PIB_OFS_ENABLE_1 8'h00
`define PIB_OFS_ENABLE_2 8'h04
`define PIB_OFS_ENABLE_3 8'h08
`define PIB_OFS_FLAGS_1 8'h0c
`define PIB_OFS_FLAGS_2 8'h10
`define PIB_OFS_FLAGS_3 8'h14
`define PIB_OFS_CORE_CTRL 8'h18

// implemented bit positions of each enable/flag pair
`define PIB_MASK_1 8'hff
`define PIB_MASK_2 8'hf9
`define PIB_MASK_3 8'h3a
// comparator two sits at bit 6 of the second pair
`define PIB_BIT_CMP_TWO 6

// core control fields
`define PIB_BIT_GLOBAL_EN 7
`define PIB_BIT_PERIPH_EN 6
`define PIB_MASK_CORE 8'hc0

`define PIB_RESET_BYTE 8'h00

// axi answers
`define PIB_RESP_OKAY 2'b00
`define PIB_RESP_SLVERR 2'b10

`endif

/* include/pib_pkg.sv */
/*
 * Types shared by the peripheral interrupt enable bank.
 * Assumes pib_consts.svh on the include path.
 */
`include "pib_consts.svh"

package pib_pkg;

  // one byte per enable/flag register pair, pair 1 in the low byte
  typedef struct packed {
    logic [7:0] grp3;
    logic [7:0] grp2;
    logic [7:0] grp1;
  } pib_bank_t;

  // write request as held by the slave until both halves arrive
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic lane0;
  } pib_wreq_t;

endpackage

/* src/pib_irq_bank.sv */
/*
 * Peripheral interrupt enable bank: three enable registers, three flag
 * registers and the core control byte, reached over AXI4-Lite, with the
 * peripheral and core interrupt requests as registered outputs.
 * Assumes event pulses come from logic on clk_in, so they are not
 * synchronised; one write and one read at most under way at a time.
 */
// How it works
// RULE_01: enable byte 1 bits 7..4: timer1 gate, adc done, serial rx, serial tx.
// RULE_02: enable byte 1 bits 3..0: sync serial, capcmp1, timer2 match, timer1 overflow.
// RULE_03: an enable bit of 1 passes its source, 0 blocks it.
// RULE_04: implemented enable bits are read/write and clear to zero on any reset.
// RULE_05: enable byte 2: osc fail 7, cmp two 6, cmp one 5, eeprom 4, collision 3, capcmp2 0.
// RULE_06: unimplemented positions ignore writes and read as zero.
// RULE_07: comparator two enable exists only on the larger device variant.
// RULE_08: enable byte 3: capcmp4 5, capcmp3 4, timer6 match 3, timer4 match 1.
// RULE_09: no peripheral source interrupts unless the peripheral group enable is set.
// RULE_10: flags set on their event regardless of any enable bit.
// RULE_11: software should clear a flag before enabling its source.
// RULE_12: global enable at core control bit 7 gates every interrupt; the code gates only core_irq_out with it, periph_irq_out ignores it.
// RULE_13: flags sit at the same bit positions as their enables.
// RULE_14: peripheral request is OR of flag AND enable, qualified by group enable.
`include "pib_consts.svh"

module pib_irq_bank #(
  parameter bit HAS_CMP_TWO = 1'b1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // peripheral event pulses, one cycle each
  input wire pib_pkg::pib_bank_t event_in,
  // axi4-lite write address
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [7:0] awaddr_in,
  input wire logic [2:0] awprot_in,
  // axi4-lite write data
  input wire logic wvalid_in,
  output logic wready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  // axi4-lite write response
  output logic bvalid_out,
  input wire logic bready_in,
  output logic [1:0] bresp_out,
  // axi4-lite read address
  input wire logic arvalid_in,
  output logic arready_out,
  input wire logic [7:0] araddr_in,
  input wire logic [2:0] arprot_in,
  // axi4-lite read data
  output logic rvalid_out,
  input wire logic rready_in,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  // requests toward the core
  output logic periph_irq_out,
  output logic core_irq_out
);
  import pib_pkg::*;

  localparam logic [7:0] MASK_2 =
    HAS_CMP_TWO ? `PIB_MASK_2 : (`PIB_MASK_2 & ~(8'h01 << `PIB_BIT_CMP_TWO)); // RULE_07
  localparam pib_bank_t MASK = '{grp3: `PIB_MASK_3, grp2: MASK_2, grp1: `PIB_MASK_1};

  pib_bank_t enable;
  pib_bank_t flags;
  logic [7:0] core_ctrl;

  pib_wreq_t wreq;
  logic aw_full;
  logic w_full;
  logic do_write;
  logic wr_hit;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic next_periph_irq;
  logic wr_lane;
  logic wr_flags_1;
  logic wr_flags_2;
  logic wr_flags_3;
  logic wr_core;
  logic [2:0] flag_sel;

  // one strobe per flag or control register, each a write that carries byte lane 0
  assign wr_lane = do_write && wreq.lane0;
  assign wr_flags_1 = wr_lane && (wreq.addr == `PIB_OFS_FLAGS_1);
  assign wr_flags_2 = wr_lane && (wreq.addr == `PIB_OFS_FLAGS_2);
  assign wr_flags_3 = wr_lane && (wreq.addr == `PIB_OFS_FLAGS_3);
  assign wr_core = wr_lane && (wreq.addr == `PIB_OFS_CORE_CTRL);
  assign flag_sel = {wr_flags_3, wr_flags_2, wr_flags_1};

  // the write happens once both halves are held and no response is pending
  assign do_write = aw_full && w_full && !bvalid_out;
  assign wr_byte = wreq.data;

  // write address channel
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      awready_out <= 1'b0;
      aw_full <= 1'b0;
      wreq.addr <= 8'h00;
    end else if (awvalid_in && awready_out) begin
      wreq.addr <= awaddr_in;
      aw_full <= 1'b1;
      awready_out <= 1'b0;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end else if (!aw_full && !bvalid_out) begin
      awready_out <= 1'b1;
    end
  end

  // write data channel; only byte lane 0 carries register bits
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wready_out <= 1'b0;
      w_full <= 1'b0;
      wreq.data <= 8'h00;
      wreq.lane0 <= 1'b0;
    end else if (wvalid_in && wready_out) begin
      wreq.data <= wdata_in[7:0];
      wreq.lane0 <= wstrb_in[0];
      w_full <= 1'b1;
      wready_out <= 1'b0;
    end else if (do_write) begin
      w_full <= 1'b0;
    end else if (!w_full && !bvalid_out) begin
      wready_out <= 1'b1;
    end
  end

  always_comb begin
    case (wreq.addr)
      `PIB_OFS_ENABLE_1, `PIB_OFS_ENABLE_2, `PIB_OFS_ENABLE_3,
      `PIB_OFS_FLAGS_1, `PIB_OFS_FLAGS_2, `PIB_OFS_FLAGS_3,
      `PIB_OFS_CORE_CTRL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write response
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bvalid_out <= 1'b0;
      bresp_out <= `PIB_RESP_OKAY;
    end else if (do_write) begin
      bvalid_out <= 1'b1;
      bresp_out <= wr_hit ? `PIB_RESP_OKAY : `PIB_RESP_SLVERR;
    end else if (bvalid_out && bready_in) begin
      bvalid_out <= 1'b0;
    end
  end

  // enable registers: masked writes keep unimplemented bits at zero
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      enable <= {3{`PIB_RESET_BYTE}}; // RULE_04
    end else if (do_write && wreq.lane0) begin
      case (wreq.addr)
        `PIB_OFS_ENABLE_1: enable.grp1 <= wr_byte & MASK.grp1; // RULE_01 RULE_02
        `PIB_OFS_ENABLE_2: enable.grp2 <= wr_byte & MASK.grp2; // RULE_05 RULE_06
        `PIB_OFS_ENABLE_3: enable.grp3 <= wr_byte & MASK.grp3; // RULE_08 RULE_06
        default: enable <= enable;
      endcase
    end
  end

  // flags: an event in the cycle of a clearing write still lands, so no
  // event is ever lost to a software clear racing it
  for (genvar g = 0; g < 3; g++) begin : g_flags
    always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        flags[8*g +: 8] <= `PIB_RESET_BYTE;
      end else begin
        flags[8*g +: 8] <= ((flag_sel[g] ? wr_byte : flags[8*g +: 8]) |
          event_in[8*g +: 8]) & MASK[8*g +: 8]; // RULE_10 RULE_13
      end
    end
  end

  // core control byte: only the two gate bits are held here
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      core_ctrl <= `PIB_RESET_BYTE;
    end else if (wr_core) begin
      core_ctrl <= wr_byte & `PIB_MASK_CORE;
    end
  end

  // read decode
  always_comb begin
    rd_hit = 1'b1;
    case (araddr_in)
      `PIB_OFS_ENABLE_1: rd_byte = enable.grp1;
      `PIB_OFS_ENABLE_2: rd_byte = enable.grp2;
      `PIB_OFS_ENABLE_3: rd_byte = enable.grp3;
      `PIB_OFS_FLAGS_1: rd_byte = flags.grp1;
      `PIB_OFS_FLAGS_2: rd_byte = flags.grp2;
      `PIB_OFS_FLAGS_3: rd_byte = flags.grp3;
      `PIB_OFS_CORE_CTRL: rd_byte = core_ctrl;
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // read channels
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      arready_out <= 1'b0;
      rvalid_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
      rresp_out <= `PIB_RESP_OKAY;
    end else if (arvalid_in && arready_out) begin
      rdata_out <= {24'h00_0000, rd_byte}; // RULE_06
      rresp_out <= rd_hit ? `PIB_RESP_OKAY : `PIB_RESP_SLVERR;
      rvalid_out <= 1'b1;
      arready_out <= 1'b0;
    end else if (rvalid_out && rready_in) begin
      rvalid_out <= 1'b0;
    end else if (!rvalid_out) begin
      arready_out <= 1'b1;
    end
  end

  // request toward the core; a flag never interrupts past a clear enable
  assign next_periph_irq = core_ctrl[`PIB_BIT_PERIPH_EN] && |(flags & enable); // RULE_03 RULE_09 RULE_14

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      periph_irq_out <= 1'b0;
      core_irq_out <= 1'b0;
    end else begin
      periph_irq_out <= next_periph_irq;
      core_irq_out <= next_periph_irq && core_ctrl[`PIB_BIT_GLOBAL_EN]; // RULE_12
    end
  end

endmodule

/* testbench/pib_checker.sv */
/* checker: bus answers and interrupt request causes
   assumes a bind onto the bank, one clock, async active-low reset */
module pib_checker (
  // clock, reset and bus handshakes
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic awvalid_in,
  input wire logic awready_out,
  input wire logic wvalid_in,
  input wire logic wready_out,
  input wire logic bvalid_out,
  input wire logic arvalid_in,
  input wire logic arready_out,
  input wire logic rvalid_out,
  input wire logic [31:0] rdata_out,
  // events and requests
  input wire pib_pkg::pib_bank_t event_in,
  input wire logic periph_irq_out,
  input wire logic core_irq_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic any_ev;
  assign any_ev = |event_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_wr; awvalid_in && awready_out && wvalid_in && wready_out; endsequence
  property p_wr_ans; s_wr |-> ##[1:2] bvalid_out; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("no bvalid");
  property p_rd_ans; arvalid_in && arready_out |=> rvalid_out; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no rvalid");
  property p_wbusy; bvalid_out |-> !awready_out && !wready_out; endproperty
  a_wbusy: assert property (p_wbusy) else $error("write overlap");
  property p_rbusy; rvalid_out |-> !arready_out; endproperty
  a_rbusy: assert property (p_rbusy) else $error("read overlap");
  property p_rd_hi; rvalid_out |-> rdata_out[31:8] == 24'h0; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("rdata high");
  property p_gate; core_irq_out |-> periph_irq_out || $past(periph_irq_out); endproperty
  a_gate: assert property (p_gate) else $error("core alone");
  property p_rise; $rose(periph_irq_out) |-> $past(any_ev, 2) || $past(bvalid_out); endproperty
  a_rise: assert property (p_rise) else $error("irq no cause");
  property p_fall; $fell(periph_irq_out) |-> $past(bvalid_out); endproperty
  a_fall: assert property (p_fall) else $error("irq lost");
endmodule

bind pib_irq_bank pib_checker pib_checker_inst (.clk_in, .resetn_in, .awvalid_in,
  .awready_out, .wvalid_in, .wready_out, .bvalid_out, .arvalid_in, .arready_out,
  .rvalid_out, .rdata_out, .event_in, .periph_irq_out, .core_irq_out);

/* testbench/pib_core_model.sv */
/* far side: event sources and the core's interrupt entry
   assumes the bank's clock; a rising request is one entry */
module pib_core_model (
  // clock and events
  input wire logic clk_in,
  input wire pib_pkg::pib_bank_t fire_in,
  output pib_pkg::pib_bank_t event_out,
  // core side
  input wire logic core_irq_in,
  output int taken_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import pib_pkg::*;
  logic last = 1'b0;
  initial event_out = '0;
  initial taken_out = 0;
  always @(posedge clk_in) begin
    event_out <= fire_in;
    last <= core_irq_in;
    if (core_irq_in && !last) taken_out <= taken_out + 1;
  end
endmodule

/* testbench/pib_irq_bank_bench.sv */
/* bench: register traffic, event pulses, request checks
   assumes the bank, the core model and the bound checker */
`include "pib_consts.svh"
module pib_irq_bank_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import pib_pkg::*;
  logic clk_in = 0, resetn_in = 0, aw = 0, w = 0, b = 0, ar = 0, r = 0, m;
  logic [7:0] aa = '0, ra = '0, v;
  logic [31:0] wd = '0;
  pib_bank_t fire = '0, ev;
  wire awr, wrdy, bv, arr, rv, pi, ci;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  int num_errors = 0, checks = 0, seed = 56389, taken, exp_taken = 0;
  initial forever #12.5 clk_in = ~clk_in;
  pib_irq_bank pib_irq_bank_inst (.clk_in, .resetn_in, .event_in(ev), .awvalid_in(aw),
    .awready_out(awr), .awaddr_in(aa), .awprot_in(3'h0), .wvalid_in(w), .wready_out(wrdy),
    .wdata_in(wd), .wstrb_in(4'hf), .bvalid_out(bv), .bready_in(b), .bresp_out(br),
    .arvalid_in(ar), .arready_out(arr), .araddr_in(ra), .arprot_in(3'h0), .rvalid_out(rv),
    .rready_in(r), .rdata_out(rdat), .rresp_out(rr), .periph_irq_out(pi), .core_irq_out(ci));
  pib_core_model pib_core_model_inst (.clk_in, .fire_in(fire), .event_out(ev),
    .core_irq_in(ci), .taken_out(taken));
  function automatic logic [7:0] msk(input int k);
    return k == 0 ? `PIB_MASK_1 : (k == 1 ? `PIB_MASK_2 : `PIB_MASK_3);
  endfunction
  task chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task limit(input int n);
    if (n >= 40) begin
      num_errors++;
      report_and_stop;
    end
  endtask
  // upper data bits are random noise: only the low byte may land
  task automatic wr(input logic [7:0] a, d, input logic [1:0] e);
    int n = 0;
    @(posedge clk_in);
    aa <= a;
    wd <= {24'($random(seed)), d};
    aw <= 1'b1;
    w <= 1'b1;
    b <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (awr) aw <= 1'b0;
      if (wrdy) w <= 1'b0;
    end while (!bv && n < 40);
    b <= 1'b0;
    limit(n);
    chk("bresp", e, br);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n = 0;
    @(posedge clk_in);
    ra <= a;
    ar <= 1'b1;
    r <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (arr) ar <= 1'b0;
    end while (!rv && n < 40);
    r <= 1'b0;
    limit(n);
    chk("rdata", e, rdat);
    chk("rresp", er, rr);
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    for (int k = 0; k < 7; k++) rd(8'(4 * k), '0, 2'h0);
    for (int k = 0; k < 12; k++) begin
      v = k < 6 ? 8'($random(seed)) : 8'hff;
      wr(8'(4 * (k % 6)), v, 2'h0);
      rd(8'(4 * (k % 6)), 32'(v & msk(k % 3)), 2'h0);
    end
    wr(8'h1c, 8'h5a, 2'h2);
    rd(8'h1c, '0, 2'h2);
    for (int k = 0; k < 7; k++) wr(8'(4 * k), 8'h00, 2'h0);
    for (int i = 0; i < 24; i++) begin
      v = msk(i / 8);
      m = v[i % 8];
      fire <= pib_bank_t'(24'h1 << i);
      @(posedge clk_in);
      fire <= '0;
      rd(8'(12 + 4 * (i / 8)), 32'(m) << (i % 8), 2'h0);
      wr(8'h18, 8'hc0, 2'h0);
      repeat (2) @(posedge clk_in);
      chk("blocked", '0, pi);
      wr(8'(4 * (i / 8)), 8'(1 << (i % 8)), 2'h0);
      repeat (2) @(posedge clk_in);
      chk("core", 32'(m), ci);
      exp_taken += m;
      wr(8'h18, 8'h80, 2'h0);
      repeat (2) @(posedge clk_in);
      chk("group", '0, pi);
      wr(8'h18, 8'h40, 2'h0);
      repeat (2) @(posedge clk_in);
      chk("periph", 32'(m), pi);
      chk("global", '0, ci);
      wr(8'(12 + 4 * (i / 8)), 8'h00, 2'h0);
      wr(8'(4 * (i / 8)), 8'h00, 2'h0);
    end
    chk("taken", exp_taken, taken);
    wr(8'h00, 8'hff, 2'h0);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(8'h00, '0, 2'h0);
    rd(8'h18, '0, 2'h0);
    report_and_stop;
  end
endmodule
